//--- ubdl_defs.vh
// shared constants for the baud, dma and loop-back channel logic
`ifndef UBDL_DEFS_VH
`define UBDL_DEFS_VH
// ----------------------------------------------------------------
// register addresses (a2..a0)
// ----------------------------------------------------------------
`define UBDL_A_DATA    3'h0
`define UBDL_A_IER     3'h1
`define UBDL_A_ISRFCR  3'h2
`define UBDL_A_LCR     3'h3
`define UBDL_A_MCR     3'h4
`define UBDL_A_LSR     3'h5
`define UBDL_A_MSR     3'h6
`define UBDL_A_SPR     3'h7
`define UBDL_A_DLL     3'h0
`define UBDL_A_DLM     3'h1
`define UBDL_A_AFR     3'h2
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UBDL_LCR_DLAB  7
`define UBDL_LCR_BRK   6
`define UBDL_LCR_STICK 5
`define UBDL_LCR_EVEN  4
`define UBDL_LCR_PEN   3
`define UBDL_LCR_STOP  2
`define UBDL_MCR_LOOP  4
`define UBDL_MCR_INTEN 3
`define UBDL_MCR_OP1   2
`define UBDL_MCR_RTS   1
`define UBDL_MCR_DTR   0
`define UBDL_FCR_DMA   3
`define UBDL_FCR_TXRST 2
`define UBDL_FCR_RXRST 1
`define UBDL_FCR_EN    0
`define UBDL_IER_RX    0
`define UBDL_IER_TX    1
`define UBDL_IER_LS    2
`define UBDL_IER_MS    3
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define UBDL_RST_BYTE  8'h00
`define UBDL_RST_SPR   8'hFF
`define UBDL_RST_DIV   16'h0001
// ----------------------------------------------------------------
// timing and levels
// ----------------------------------------------------------------
`define UBDL_CLK_HZ      100000000
`define UBDL_REF_MAX_HZ  80000000
`define UBDL_RATE_MAX    5000000
`define UBDL_EX_REF_HZ   1843200
`define UBDL_EX_DIV      16'h000C
`define UBDL_EX_BPS      9600
`define UBDL_OVS_LAST    4'hF
`define UBDL_OVS_HALF    4'h7
`define UBDL_WL_BASE     4'h5
`define UBDL_TX_TRIG     5'h10
`define UBDL_RX_TRIG0    5'h01
`define UBDL_RX_TRIG1    5'h04
`define UBDL_RX_TRIG2    5'h08
`define UBDL_RX_TRIG3    5'h0E
// ----------------------------------------------------------------
// interrupt identity codes (isr bits 3..1)
// ----------------------------------------------------------------
`define UBDL_ID_LS     3'h3
`define UBDL_ID_RX     3'h2
`define UBDL_ID_TX     3'h1
`define UBDL_ID_MS     3'h0
`endif

//--- ubdl_buf2.v
// two-entry valid/ready buffer for the transmit data path
`timescale 1ns/1ps
module ubdl_buf2 #(
  parameter WIDTH = 8
) (
  input  wire             ref_clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [1:0]       level
);
  reg [WIDTH-1:0] mem_q [0:1];  // entry storage
  reg             wp_q;         // write pointer
  reg             rp_q;         // read pointer
  reg [1:0]       cnt_q;        // entries held

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  // ----------------------------------------------------------------
  // entry writes, one per slot
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_ent
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          mem_q[i] <= {WIDTH{1'b0}};
        end else if (push && (wp_q == i)) begin
          mem_q[i] <= in_data;
        end
      end
    end
  endgenerate

  // pointers and count; flush drops everything held
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (flush) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- ubdl_channel.v
// one serial channel: baud generator, dma signalling and loop-back
//
// What this block does
// - every channel instance owns its baud generator
// - reference clock up to 80 MHz, 5 Mbit/s
// - divide by programmable divisor 1 to 65535
// - extra divide by 16 per bit
// - divisor is high byte plus low byte
// - 1.8432 MHz, divisor 12 gives 9600
// - clock from crystal or external clock input
// - line status bits 5, 6: free, empty
// - fifo control bit 3 picks dma mode
// - mode 0: interrupt for every character
// - mode 1: tx below 16, rx above trigger
// - loop-back: modem pins cut, control bits drive
// - loop-back: tx fed to rx internally
// - loop-back: dtr to cts, rts to dsr
// - loop-back: int enable to cd, bit 2 ri
// - loop-back byte readable back in receive register
// - loop-back interrupts still work, still enabled
// - loop-back: only change bits of modem status
// - divisor registers only when latch enable set
`timescale 1ns/1ps
`include "ubdl_defs.vh"
module ubdl_channel #(
  parameter DIV_W = 16
) (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       cs_n,
  input  wire [2:0] addr,
  input  wire       wr_stb,
  input  wire       rd_stb,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  input  wire       rx_pin,
  output wire       tx_pin,
  input  wire       cts_n_pin,
  input  wire       dsr_n_pin,
  input  wire       cd_n_pin,
  input  wire       ri_n_pin,
  output wire       dtr_n_pin,
  output wire       rts_n_pin,
  output wire       op1_n_pin,
  output wire       op2_n_pin,
  output reg        int_out,
  output wire       crystal_out_pin
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [4:0] sync1_q;  // first stage, read only by sync2_q
  reg [4:0] sync2_q;  // {ri, cd, dsr, cts, rx}, all idle high

  // two flops per asynchronous pin
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
    end else begin
      sync1_q <= {ri_n_pin, cd_n_pin, dsr_n_pin, cts_n_pin, rx_pin};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // registers and bus decode
  // ----------------------------------------------------------------
  reg [3:0]       ier_q;   // interrupt enables
  reg [7:0]       lcr_q;   // line control
  reg [4:0]       mcr_q;   // modem control
  reg [7:0]       fcr_q;   // fifo control, reset bits not kept
  reg [7:0]       spr_q;   // scratchpad
  reg [7:0]       afr_q;   // alternate function, stored only
  reg [7:0]       dll_q;   // divisor low byte
  reg [7:0]       dlm_q;   // divisor high byte

  wire sel    = ~cs_n;
  wire dlab   = lcr_q[`UBDL_LCR_DLAB];
  // latch enable opens only the three low addresses
  wire spc    = dlab & (addr <= `UBDL_A_AFR);
  wire wr_gen = sel & wr_stb & ~spc;
  wire wr_spc = sel & wr_stb & spc;
  wire rd_gen = sel & rd_stb & ~spc;
  wire thr_wr = wr_gen & (addr == `UBDL_A_DATA);
  wire fcr_wr = wr_gen & (addr == `UBDL_A_ISRFCR);
  wire txrst  = fcr_wr & wr_data[`UBDL_FCR_TXRST];
  wire rxrst  = fcr_wr & wr_data[`UBDL_FCR_RXRST];
  wire rhr_rd = rd_gen & (addr == `UBDL_A_DATA);
  wire lsr_rd = rd_gen & (addr == `UBDL_A_LSR);
  wire msr_rd = rd_gen & (addr == `UBDL_A_MSR);
  wire loop   = mcr_q[`UBDL_MCR_LOOP];

  // software writes; reset bits of fifo control act as pulses
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ier_q <= 4'h0;
      lcr_q <= `UBDL_RST_BYTE;
      mcr_q <= 5'h00;
      fcr_q <= `UBDL_RST_BYTE;
      spr_q <= `UBDL_RST_SPR;
      afr_q <= `UBDL_RST_BYTE;
      {dlm_q, dll_q} <= `UBDL_RST_DIV;
    end else begin
      if (wr_gen) begin
        case (addr)
          `UBDL_A_IER:    ier_q <= wr_data[3:0];
          `UBDL_A_ISRFCR: fcr_q <= wr_data & 8'hC9;
          `UBDL_A_LCR:    lcr_q <= wr_data;
          `UBDL_A_MCR:    mcr_q <= wr_data[4:0];
          `UBDL_A_SPR:    spr_q <= wr_data;
          default:        ;                          // data goes to the tx buffer via thr_wr; lsr and msr read-only
        endcase
      end
      if (wr_spc) begin
        case (addr)
          `UBDL_A_DLL: dll_q <= wr_data;
          `UBDL_A_DLM: dlm_q <= wr_data;
          default:     afr_q <= wr_data;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // ref_clk is the crystal or external clock on the input pin; no
  // oscillator is modelled, so the crystal output sits low
  assign crystal_out_pin = 1'b0;

  wire [DIV_W-1:0] div_w   = {dlm_q, dll_q};
  // zero is not a legal divisor; it runs as one
  wire [DIV_W-1:0] div_eff = (div_w == {DIV_W{1'b0}}) ? {{(DIV_W-1){1'b0}}, 1'b1} : div_w;
  reg  [DIV_W-1:0] bcnt_q;                           // per-channel counter
  wire             tick    = (bcnt_q == {DIV_W{1'b0}});  // 16x rate

  // divisor is sampled only at reload, so a write mid-frame takes effect
  // at the next reload and never truncates the current count
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bcnt_q <= {DIV_W{1'b0}};
    end else if (tick) begin
      bcnt_q <= div_eff - 1'b1;
    end else begin
      bcnt_q <= bcnt_q - 1'b1;
    end
  end
  // bit rate = ref / (16 * divisor): 1.8432 MHz, 12 gives 9600;
  // at the 80 MHz ceiling, divisor 1 gives 5 Mbit/s

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  wire [3:0] wl = `UBDL_WL_BASE + {2'b00, lcr_q[1:0]};  // data bits
  wire       pen = lcr_q[`UBDL_LCR_PEN];

  // parity of a masked character, honouring stick and even
  function par_of;
    input [7:0] m;
    input [7:0] line_control_reg;
    begin
      if (line_control_reg[`UBDL_LCR_STICK]) begin
        par_of = ~line_control_reg[`UBDL_LCR_EVEN];
      end else if (line_control_reg[`UBDL_LCR_EVEN]) begin
        par_of = ^m;
      end else begin
        par_of = ~^m;
      end
    end
  endfunction

  wire [7:0] tx_data;      // head of the buffer
  wire       tx_avail;     // buffer holds a byte
  wire       thr_free;     // buffer can take a byte
  wire [1:0] tx_level;     // bytes held
  reg        tx_busy_q;    // frame on the wire
  reg [11:0] tx_frame_q;   // shifted out lsb first
  reg [3:0]  tx_bits_q;    // bits left in frame
  reg [3:0]  tx_ph_q;      // 16x phase in the bit

  // a write while the buffer is full is lost; poll free first
  ubdl_buf2 #(
    .WIDTH (8)
  ) u_txbuf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (txrst),
    .in_valid  (thr_wr),
    .in_ready  (thr_free),
    .in_data   (wr_data),
    .out_valid (tx_avail),
    .out_ready (~tx_busy_q),
    .out_data  (tx_data),
    .level     (tx_level)
  );

  wire [7:0]  tx_m     = tx_data & (8'hFF >> (4'h8 - wl));
  wire [11:0] tx_build = {3'h7, tx_m, 1'b0} | (12'hFFF << (wl + 4'h1));
  wire [3:0]  tx_len   = 4'h2 + wl + {3'h0, pen} + {3'h0, lcr_q[`UBDL_LCR_STOP]};

  // load a frame when idle, then one bit per 16 ticks
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_busy_q  <= 1'b0;
      tx_frame_q <= 12'hFFF;
      tx_bits_q  <= 4'h0;
      tx_ph_q    <= 4'h0;
    end else if (!tx_busy_q) begin
      if (tx_avail) begin
        tx_busy_q  <= 1'b1;
        tx_frame_q <= tx_build;
        if (pen) begin
          tx_frame_q[wl + 4'h1] <= par_of(tx_m, lcr_q);
        end
        tx_bits_q  <= tx_len;
        tx_ph_q    <= 4'h0;
      end
    end else if (tick) begin
      tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_ph_q == `UBDL_OVS_LAST) begin
        tx_frame_q <= {1'b1, tx_frame_q[11:1]};
        tx_bits_q  <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  wire tx_line = (tx_busy_q ? tx_frame_q[0] : 1'b1) & ~lcr_q[`UBDL_LCR_BRK];
  // pin idles at mark in loop-back; stream goes to the receiver
  assign tx_pin = loop ? 1'b1 : tx_line;
  wire   rx_in  = loop ? tx_line : sync2_q[0];

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  localparam RX_IDLE  = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS  = 2'h2;

  reg [1:0]  rx_st_q;      // receiver state
  reg        rx_prev_q;    // last line level, for start edge
  reg [3:0]  rx_ph_q;      // 16x phase
  reg [3:0]  rx_idx_q;     // bit index in frame
  reg [9:0]  rx_sh_q;      // collected data and parity
  reg [7:0]  rhr_q;        // received character
  reg        rhr_valid_q;  // data ready
  reg        oe_q;         // overrun, sticky
  reg        pe_q;         // parity error, sticky
  reg        fe_q;         // framing error, sticky
  reg        bi_q;         // break, sticky

  wire [3:0] rx_last = wl + {3'h0, pen};              // stop bit index
  wire [7:0] rx_m    = rx_sh_q[7:0] & (8'hFF >> (4'h8 - wl));
  wire       rx_done = (rx_st_q == RX_BITS) && tick &&
                       (rx_ph_q == `UBDL_OVS_LAST) && (rx_idx_q == rx_last);
  wire       rx_pbad = pen & (rx_sh_q[wl] != par_of(rx_m, lcr_q));
  wire       rx_brk  = ~rx_in & (rx_m == 8'h00) & ~(pen & rx_sh_q[wl]);

  // start found on a falling edge, checked at mid bit, then sampled
  // at each bit centre; false starts drop back to idle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st_q   <= RX_IDLE;
      rx_prev_q <= 1'b1;
      rx_ph_q   <= 4'h0;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 10'h000;
    end else begin
      rx_prev_q <= rx_in;
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_in) begin
            rx_st_q <= RX_START;
            rx_ph_q <= 4'h0;
          end
        end
        RX_START: begin
          if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `UBDL_OVS_HALF) begin
              rx_st_q  <= rx_in ? RX_IDLE : RX_BITS;
              rx_ph_q  <= 4'h0;
              rx_idx_q <= 4'h0;
            end
          end
        end
        RX_BITS: begin
          if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `UBDL_OVS_LAST) begin
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_last) begin
                rx_st_q <= RX_IDLE;
              end else begin
                rx_sh_q[rx_idx_q] <= rx_in;
              end
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // holding register and line errors; new events win over clears
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rhr_q       <= 8'h00;
      rhr_valid_q <= 1'b0;
      oe_q        <= 1'b0;
      pe_q        <= 1'b0;
      fe_q        <= 1'b0;
      bi_q        <= 1'b0;
    end else begin
      if (rhr_rd || rxrst) begin
        rhr_valid_q <= 1'b0;
      end
      if (lsr_rd) begin
        oe_q <= 1'b0;
        pe_q <= 1'b0;
        fe_q <= 1'b0;
        bi_q <= 1'b0;
      end
      if (rx_done) begin
        rhr_q       <= rx_m;
        rhr_valid_q <= 1'b1;
        if (rhr_valid_q && !rhr_rd) begin
          oe_q <= 1'b1;
        end
        if (rx_pbad) begin
          pe_q <= 1'b1;
        end
        if (!rx_in) begin
          fe_q <= 1'b1;
        end
        if (rx_brk) begin
          bi_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // modem lines
  // ----------------------------------------------------------------
  // internal levels {cd, ri, dsr, cts} in loop-back, {ri, cd, dsr, cts} from the pins; true = asserted
  wire [3:0] ms_lvl = loop ? {mcr_q[`UBDL_MCR_INTEN], mcr_q[`UBDL_MCR_OP1],
                              mcr_q[`UBDL_MCR_RTS], mcr_q[`UBDL_MCR_DTR]}
                           : ~sync2_q[4:1];
  reg  [3:0] ms_prev_q;   // levels one cycle ago
  reg  [3:0] ms_dlt_q;    // change bits, sticky
  wire [3:0] ms_chg = {ms_prev_q[3] ^ ms_lvl[3], ms_prev_q[2] & ~ms_lvl[2],
                       ms_prev_q[1] ^ ms_lvl[1], ms_prev_q[0] ^ ms_lvl[0]};

  // change bits; bit 2 (ri in loop-back, cd from the pins) flags its trailing edge only
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ms_prev_q <= 4'h0;
      ms_dlt_q  <= 4'h0;
    end else begin
      ms_prev_q <= ms_lvl;
      ms_dlt_q  <= (msr_rd ? 4'h0 : ms_dlt_q) | ms_chg;
    end
  end

  // pins go inactive while looped back
  assign dtr_n_pin = loop | ~mcr_q[`UBDL_MCR_DTR];
  assign rts_n_pin = loop | ~mcr_q[`UBDL_MCR_RTS];
  assign op1_n_pin = loop | ~mcr_q[`UBDL_MCR_OP1];
  assign op2_n_pin = loop | ~mcr_q[`UBDL_MCR_INTEN];

  // ----------------------------------------------------------------
  // interrupt conditions
  // ----------------------------------------------------------------
  wire       dma1 = fcr_q[`UBDL_FCR_EN] & fcr_q[`UBDL_FCR_DMA];
  wire [4:0] rx_lvl = {4'h0, rhr_valid_q};
  wire [4:0] tx_lvl = {3'h0, tx_level};
  reg  [4:0] rx_trig;  // receive trigger in characters

  // trigger level from fifo control bits 7..6
  always @* begin
    rx_trig = `UBDL_RX_TRIG0;
    case (fcr_q[7:6])
      2'h1:    rx_trig = `UBDL_RX_TRIG1;
      2'h2:    rx_trig = `UBDL_RX_TRIG2;
      2'h3:    rx_trig = `UBDL_RX_TRIG3;
      default: rx_trig = `UBDL_RX_TRIG0;
    endcase
  end

  // mode 1 uses fill levels, mode 0 each character
  wire rx_cond = dma1 ? (rx_lvl > rx_trig) : rhr_valid_q;
  wire tx_cond = dma1 ? (tx_lvl < `UBDL_TX_TRIG) : (tx_level == 2'h0);
  // same enables apply in loop-back
  wire irq_ls  = ier_q[`UBDL_IER_LS] & (oe_q | pe_q | fe_q | bi_q);
  wire irq_rx  = ier_q[`UBDL_IER_RX] & rx_cond;
  wire irq_tx  = ier_q[`UBDL_IER_TX] & tx_cond;
  wire irq_ms  = ier_q[`UBDL_IER_MS] & (|ms_dlt_q);
  wire irq_any = irq_ls | irq_rx | irq_tx | irq_ms;
  // highest pending source
  wire [2:0] irq_id = irq_ls ? `UBDL_ID_LS : irq_rx ? `UBDL_ID_RX :
                      irq_tx ? `UBDL_ID_TX : `UBDL_ID_MS;

  // output gated by the interrupt enable control bit
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_out <= 1'b0;
    end else begin
      int_out <= irq_any & mcr_q[`UBDL_MCR_INTEN];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire       temt  = (tx_level == 2'h0) & ~tx_busy_q;
  wire [7:0] lsr_v = {pe_q | fe_q | bi_q, temt, thr_free, bi_q,
                      fe_q, pe_q, oe_q, rhr_valid_q};
  // level half blanked while looped back
  wire [7:0] msr_v = {loop ? 4'h0 : ms_lvl, ms_dlt_q};
  wire       fen   = fcr_q[`UBDL_FCR_EN];

  // registered read mux; value is valid the cycle after rd_stb
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (sel && rd_stb) begin
      if (spc) begin
        case (addr)
          `UBDL_A_DLL: rd_data <= dll_q;
          `UBDL_A_DLM: rd_data <= dlm_q;
          default:     rd_data <= afr_q;
        endcase
      end else begin
        case (addr)
          `UBDL_A_DATA:   rd_data <= rhr_q;
          `UBDL_A_IER:    rd_data <= {4'h0, ier_q};
          `UBDL_A_ISRFCR: rd_data <= {fen, fen, 2'h0, irq_id, ~irq_any};
          `UBDL_A_LCR:    rd_data <= lcr_q;
          `UBDL_A_MCR:    rd_data <= {3'h0, mcr_q};
          `UBDL_A_LSR:    rd_data <= lsr_v;
          `UBDL_A_MSR:    rd_data <= msr_v;
          default:        rd_data <= spr_q;
        endcase
      end
    end
  end
endmodule

//--- ubdl_chk_sva.sv
// checker for one channel: bus shadows, modem outputs, loop-back
`timescale 1ns/1ps
module ubdl_chk (
  input wire       ref_clk,
  input wire       rst,
  input wire       cs_n,
  input wire [2:0] addr,
  input wire       wr_stb,
  input wire       rd_stb,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire       tx_pin,
  input wire       dtr_n_pin,
  input wire       rts_n_pin,
  input wire       op1_n_pin,
  input wire       op2_n_pin,
  input wire       int_out
);
  reg  [7:0] lcr_q;                     // shadow of line control
  reg  [4:0] mcr_q;                     // shadow of modem control
  reg  [7:0] dll_q;                     // shadow of divisor low
  reg  [7:0] dlm_q;                     // shadow of divisor high
  wire       wr_go = !cs_n && wr_stb;   // write taken
  wire       rd_go = !cs_n && rd_stb;   // read taken
  // shadows follow host writes; divisor only behind the latch bit
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lcr_q <= 8'h00;
      mcr_q <= 5'h00;
      dll_q <= 8'h01;
      dlm_q <= 8'h00;
    end else if (wr_go) begin
      if (addr == 3'h3) lcr_q <= wr_data;
      if (addr == 3'h4) mcr_q <= wr_data[4:0];
      if (lcr_q[7] && addr == 3'h0) dll_q <= wr_data;
      if (lcr_q[7] && addr == 3'h1) dlm_q <= wr_data;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_dtr_rts_map: assert property (dtr_n_pin == (mcr_q[4] | ~mcr_q[0])
    && rts_n_pin == (mcr_q[4] | ~mcr_q[1])) else $error("dtr or rts pin wrong");
  chk_op_map: assert property (op1_n_pin == (mcr_q[4] | ~mcr_q[2])
    && op2_n_pin == (mcr_q[4] | ~mcr_q[3])) else $error("op pin wrong");
  chk_tx_loop_mark: assert property (mcr_q[4] |-> tx_pin)
    else $error("tx pin active in loop-back");
  chk_int_gated: assert property (int_out |-> $past(mcr_q[3]))
    else $error("interrupt without output enable");
  chk_rd_hold: assert property (!rd_go |=> $stable(rd_data))
    else $error("read data moved without read");
  chk_dll_read: assert property (rd_go && lcr_q[7] && addr == 3'h0 |=> rd_data == dll_q)
    else $error("divisor low read wrong");
  chk_dlm_read: assert property (rd_go && lcr_q[7] && addr == 3'h1 |=> rd_data == dlm_q)
    else $error("divisor high read wrong");
  chk_msr_upper: assert property (rd_go && mcr_q[4] && addr == 3'h6 |=> rd_data[7:4] == 4'h0)
    else $error("modem level bits seen in loop-back");
  cover property (rd_go && mcr_q[4] && addr == 3'h6);
  cover property ($rose(int_out));
  cover property (rd_go && lcr_q[7] && addr == 3'h1);
endmodule
bind ubdl_channel ubdl_chk u_ubdl_chk (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .addr(addr), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data),
  .tx_pin(tx_pin), .dtr_n_pin(dtr_n_pin), .rts_n_pin(rts_n_pin), .op1_n_pin(op1_n_pin),
  .op2_n_pin(op2_n_pin), .int_out(int_out));

//--- ubdl_modem.sv
// far-side serial device: sends frames, can disturb cut lines
`timescale 1ns/1ps
module ubdl_modem (
  input  wire       ref_clk,
  input  wire       noise,
  output reg        rx_pin,
  output reg  [3:0] mdm_n
);
  reg tx_act = 1'b0;  // frame in flight, idle logic keeps off
  initial rx_pin = 1'b1;
  initial mdm_n = 4'hF;
  // lines toggle each cycle so a leaky loop-back shows up
  always @(posedge ref_clk) begin
    if (noise) begin
      rx_pin <= ~rx_pin;
      mdm_n <= ~mdm_n;
    end else if (!tx_act) begin
      rx_pin <= 1'b1;
      mdm_n <= 4'hF;
    end
  end
  // 8n1 frame, lsb first, bitc cycles a bit
  task send(input [7:0] b, input integer bitc);
    integer i;
    begin
      tx_act = 1'b1;
      rx_pin <= 1'b0;
      repeat (bitc) @(posedge ref_clk);
      for (i = 0; i < 9; i = i + 1) begin
        rx_pin <= (i == 8) ? 1'b1 : b[i];
        repeat (bitc) @(posedge ref_clk);
      end
      tx_act = 1'b0;
    end
  endtask
endmodule

//--- ubdl_channel_test.sv
// self-checking bench for one serial channel
`timescale 1ns/1ps
module ubdl_channel_test;
  localparam BITC = 32;               // divisor 2 times 16
  reg        ref_clk = 1'b0;
  reg        rst = 1'b1;
  reg        cs_n = 1'b1;
  reg  [2:0] addr = 3'h0;
  reg        wr_stb = 1'b0;
  reg        rd_stb = 1'b0;
  reg  [7:0] wr_data = 8'h00;
  reg        noise = 1'b0;
  reg  [7:0] d;
  wire [7:0] rd_data;
  wire [3:0] mdm_n;
  wire       rx_pin, tx_pin, int_out, crystal_out;
  integer    err_count = 0;
  integer    checked = 0;
  integer    i;
  always #5 ref_clk = ~ref_clk;
  ubdl_modem u_ubdl_modem (.ref_clk(ref_clk), .noise(noise), .rx_pin(rx_pin), .mdm_n(mdm_n));
  ubdl_channel u_ubdl_channel (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .addr(addr),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data), .rd_data(rd_data), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .cts_n_pin(mdm_n[0]), .dsr_n_pin(mdm_n[1]), .cd_n_pin(mdm_n[2]),
    .ri_n_pin(mdm_n[3]), .dtr_n_pin(), .rts_n_pin(), .op1_n_pin(), .op2_n_pin(),
    .int_out(int_out), .crystal_out_pin(crystal_out));
  task cmp8(input string nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cmp1(input string nm, input e, input g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("[FAIL] %0s expected %b seen %b", nm, e, g);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge ref_clk);
      #1;
    end
  endtask
  // one-cycle strobe, released on the edge that takes it
  task wr(input [2:0] a, input [7:0] v);
    begin
      @(posedge ref_clk) {cs_n, wr_stb, addr, wr_data} <= {1'b0, 1'b1, a, v};
      @(posedge ref_clk) {cs_n, wr_stb} <= 2'h2;
    end
  endtask
  task rd(input [2:0] a, output [7:0] v);
    begin
      @(posedge ref_clk) {cs_n, rd_stb, addr} <= {1'b0, 1'b1, a};
      @(posedge ref_clk) {cs_n, rd_stb} <= 2'h2;
      #1 v = rd_data;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task t_regs;
    begin
      rd(3'h5, d);
      cmp8("lsr reset", 8'h60, d);
      cmp1("crystal out", 1'b0, crystal_out);
      wr(3'h5, 8'h00);
      rd(3'h5, d);
      cmp8("lsr read only", 8'h60, d);
      wr(3'h3, 8'h83);
      rd(3'h0, d);
      cmp8("dll reset", 8'h01, d);
      wr(3'h1, 8'h01);
      wr(3'h0, 8'h02);
      wr(3'h3, 8'h03);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h83);
      rd(3'h1, d);
      cmp8("dlm kept", 8'h01, d);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h03);
      tick(300); // the 0x0101 count loaded meanwhile must run out
    end
  endtask
  task t_tx_rate;
    begin
      wr(3'h0, 8'hC5);
      for (i = 0; i < 100 && tx_pin; i = i + 1) tick(1);
      tick(BITC / 2);
      cmp1("tx start", 1'b0, tx_pin);
      for (i = 0; i < 9; i = i + 1) begin
        tick(BITC);
        cmp1("tx bit", (i == 8) || (8'hC5 >> i & 8'h01), tx_pin);
      end
    end
  endtask
  task t_rx;
    begin
      u_ubdl_modem.send(8'h3A, BITC);
      tick(40);
      rd(3'h5, d);
      cmp1("rx ready", 1'b1, d[0]);
      rd(3'h0, d);
      cmp8("rx data", 8'h3A, d);
    end
  endtask
  task t_loop;
    begin
      wr(3'h4, 8'h10);
      @(posedge ref_clk) noise <= 1'b1;
      tick(4);
      rd(3'h6, d);
      wr(3'h0, 8'h96);
      d = 8'h00;
      for (i = 0; i < 400 && !d[0]; i = i + 1) rd(3'h5, d);
      rd(3'h0, d);
      cmp8("loop data", 8'h96, d);
      wr(3'h4, 8'h13);
      tick(4);
      rd(3'h6, d);
      cmp8("loop msr dtr rts", 8'h03, d);
      wr(3'h4, 8'h1B);
      tick(4);
      rd(3'h6, d);
      cmp8("loop msr cd", 8'h08, d);
      @(posedge ref_clk) noise <= 1'b0;
      wr(3'h4, 8'h00);
    end
  endtask
  task t_dma;
    begin
      wr(3'h1, 8'h02);
      wr(3'h4, 8'h08);
      wr(3'h2, 8'h01);
      tick(4);
      cmp1("int tx empty", 1'b1, int_out);
      wr(3'h0, 8'h11);
      wr(3'h0, 8'h22);
      wr(3'h0, 8'h33);
      rd(3'h5, d);
      cmp8("lsr full", 8'h00, d & 8'h60);
      cmp1("int mode0 held", 1'b0, int_out);
      wr(3'h2, 8'h09);
      tick(4);
      cmp1("int mode1", 1'b1, int_out);
      wr(3'h2, 8'h01);
      tick(4);
      cmp1("int back mode0", 1'b0, int_out);
      d = 8'h00;
      for (i = 0; i < 1000 && !d[6]; i = i + 1) rd(3'h5, d);
      cmp8("lsr drained", 8'h60, d & 8'h60);
      tick(4);
      cmp1("int drained", 1'b1, int_out);
      wr(3'h1, 8'h00);
      tick(4);
      cmp1("int masked", 1'b0, int_out);
    end
  endtask
  initial begin
    #400000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_tx_rate;
    t_rx;
    t_loop;
    t_dma;
    tally_and_finish;
  end
endmodule
